//--- ssp_regs.svh
/*
  Bit positions, mode codes and protocol counts for the two-wire slave port.
  Assumes it is included by its bare name from the package and the modules.
*/
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define SSP_CTRL_OV_BIT 6
`define SSP_CTRL_EN_BIT 5
`define SSP_CTRL_MODE_HI 3
`define SSP_CTRL_MODE_LO 0
`define SSP_CTRL_RESET 8'h00

// ----------------------------------------------------------------------
// Mode field codes
// ----------------------------------------------------------------------
`define SSP_MODE_SLV7 4'h1
`define SSP_MODE_SLV10 4'h2
`define SSP_MODE_SLV7_INT 4'h3
`define SSP_MODE_SLV10_INT 4'h4
`define SSP_MODE_FW_MASTER 4'h5

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define SSP_STAT_DA_BIT 5
`define SSP_STAT_STOP_BIT 4
`define SSP_STAT_START_BIT 3
`define SSP_STAT_RW_BIT 2
`define SSP_STAT_UA_BIT 1
`define SSP_STAT_BF_BIT 0

// ----------------------------------------------------------------------
// Protocol counts, ten-bit prefix and address reset value
// ----------------------------------------------------------------------
`define SSP_DATA_EDGES 4'h8
`define SSP_ACK_EDGE 4'h9
`define SSP_TEN_BIT_PREFIX 5'h1E
`define SSP_ADDR_RESET 8'h00

`endif

//--- ssp_pkg.sv
/*
  Types shared by the two-wire slave port modules.
  Assumes nothing of its surroundings.
*/
`include "ssp_regs.svh"

package ssp_pkg;

  typedef enum logic [2:0] {
    SSP_ST_IDLE = 3'b000,
    SSP_ST_ADDR = 3'b001,
    SSP_ST_ADDR_LO = 3'b010,
    SSP_ST_RX = 3'b011,
    SSP_ST_TX = 3'b100,
    SSP_ST_IGNORE = 3'b101
  } ssp_state_t;

endpackage : ssp_pkg

//--- ssp_sync.sv
/*
  Two flip-flop synchroniser for a level or a gray-coded word.
  Assumes each bit of d may change at any time relative to clock.
*/
`timescale 1ns/1ns
`default_nettype none

module ssp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds the second stage only
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : ssp_sync

`default_nettype wire

//--- ssp_buf2.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes both sides run on clock; out_valid and out_data come from flops.
*/
`timescale 1ns/1ns
`default_nettype none

module ssp_buf2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  logic [WIDTH-1:0] d0_reg, d0_next, d1_reg, d1_next;
  logic v0_reg, v0_next, v1_reg, v1_next;

  assign in_ready = ~v1_reg;
  assign out_valid = v0_reg;
  assign out_data = d0_reg;

  always_comb begin
    logic pop;
    logic push;
    pop = v0_reg & out_ready;
    push = in_valid & ~v1_reg;
    d0_next = d0_reg;
    d1_next = d1_reg;
    v0_next = v0_reg;
    v1_next = v1_reg;
    if (pop) begin
      d0_next = d1_reg;
      v0_next = v1_reg;
      v1_next = 1'b0;
    end
    if (push) begin
      if (v0_next) begin
        d1_next = in_data;
        v1_next = 1'b1;
      end else begin
        d0_next = in_data;
        v0_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      d0_reg <= '0;
      d1_reg <= '0;
      v0_reg <= 1'b0;
      v1_reg <= 1'b0;
    end else begin
      d0_reg <= d0_next;
      d1_reg <= d1_next;
      v0_reg <= v0_next;
      v1_reg <= v1_next;
    end
  end

endmodule : ssp_buf2

`default_nettype wire

//--- ssp_port.sv
/*
  Two-wire slave serial port: link-side bit capture on the bus clock,
  protocol, control, status and buffering on the core clock.
  Assumes open-drain pins resolved outside, and a bus clock far slower than
  the core clock so that a captured byte is stable long before it is read.
*/
`include "ssp_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module ssp_port (
  // Core clock and reset
  input wire logic clock,
  input wire logic reset,
  // Bus clock used as link clock
  input wire logic link_clock,
  // Pins
  input wire logic clock_pin_in,
  output logic clock_pin_out,
  output logic clock_pin_oe,
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe,
  input wire logic [1:0] port_c_direction,
  // Control register access
  input wire logic ctrl_write,
  input wire logic [7:0] ctrl_wdata,
  output logic [7:0] port_control_reg,
  output logic [7:0] port_status_reg,
  // Address register access
  input wire logic addr_write,
  input wire logic [7:0] addr_wdata,
  output logic [7:0] slave_address_reg,
  // Receive side of the buffer
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // Transmit side: one-byte holding register
  input wire logic tx_write,
  input wire logic [7:0] tx_wdata,
  output logic tx_full,
  // Interrupt
  input wire logic irq_flag_clear,
  input wire logic port_irq_enable,
  output logic port_irq_flag,
  output logic irq
);
  import ssp_pkg::*;

  // ----------------------------------------------------------------------
  // Link domain: edge counter and bit shifter on the bus clock
  // ----------------------------------------------------------------------
  logic link_reset;
  logic [3:0] edge_bin_reg, edge_bin_next, edge_gray_reg, edge_gray_next;
  logic [8:0] bit_shifter, bit_shifter_next;

  ssp_sync #(.WIDTH(1)) u_link_rst (
    .clock(link_clock),
    .reset(1'b0),
    .d(reset),
    .q(link_reset)
  );

  // The shifter is never visible to software
  always_comb begin
    edge_bin_next = edge_bin_reg + 4'h1;
    edge_gray_next = edge_bin_next ^ {1'b0, edge_bin_next[3:1]};
    bit_shifter_next = {bit_shifter[7:0], data_pin_in};
  end

  always_ff @(posedge link_clock) begin
    if (link_reset) begin
      edge_bin_reg <= 4'h0;
      edge_gray_reg <= 4'h0;
      bit_shifter <= 9'h000;
    end else begin
      edge_bin_reg <= edge_bin_next;
      edge_gray_reg <= edge_gray_next;
      bit_shifter <= bit_shifter_next;
    end
  end

  // ----------------------------------------------------------------------
  // Crossings into the core domain
  // ----------------------------------------------------------------------
  logic [3:0] edge_gray_s;
  logic [1:0] pins_s;

  ssp_sync #(.WIDTH(4)) u_edge_sync (
    .clock(clock),
    .reset(reset),
    .d(edge_gray_reg),
    .q(edge_gray_s)
  );

  // Left out of reset so the pin levels are already idle-high on release,
  // otherwise the edge detector would see a false clock fall
  ssp_sync #(.WIDTH(2)) u_pin_sync (
    .clock(clock),
    .reset(1'b0),
    .d({clock_pin_in, data_pin_in}),
    .q(pins_s)
  );

  // ----------------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------------
  logic push;
  logic buf_ready;
  logic [7:0] rx_byte;

  // Two entries let the next byte shift in while one waits
  ssp_buf2 #(.WIDTH(8)) u_rx_buf (
    .clock(clock),
    .reset(reset),
    .in_valid(push),
    .in_data(rx_byte),
    .in_ready(buf_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );

  // ----------------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------------
  ssp_state_t state_reg, state_next;
  logic [3:0] base_reg, base_next;
  logic scl_q, sda_q;
  logic done_reg, done_next, ack_reg, ack_next;
  logic sda_oe_next, scl_oe_next;
  logic en_reg, en_next, ov_reg, ov_next;
  logic [3:0] mode_reg, mode_next;
  logic start_reg, start_next, stop_reg, stop_next;
  logic da_reg, da_next, rw_reg, rw_next, ua_reg, ua_next;
  logic hi_reg, hi_next;
  logic [7:0] addr_next, tx_reg, tx_next;
  logic tx_full_next, irqf_next, irq_next;
  logic [7:0] status_next;

  // Bus clock is far slower than ours, so the shifter has settled by the
  // time the synchronised count shows the edge that loaded it
  assign rx_byte = bit_shifter[7:0];

  always_comb begin
    logic [3:0] edge_bin;
    logic [3:0] nbits;
    logic scl_s, sda_s, fall, start_det, stop_det;
    logic slave, tenbit, with_int, fwm, active, irq_set, load_tx;
    edge_bin = edge_gray_s ^ {1'b0, edge_gray_s[3:1]} ^ {2'b00, edge_gray_s[3:2]} ^ {3'b000, edge_gray_s[3]};
    nbits = edge_bin - base_reg;
    scl_s = pins_s[1];
    sda_s = pins_s[0];
    fall = scl_q & ~scl_s;
    start_det = scl_s & scl_q & sda_q & ~sda_s;
    stop_det = scl_s & scl_q & ~sda_q & sda_s;
    slave = (mode_reg == `SSP_MODE_SLV7) || (mode_reg == `SSP_MODE_SLV10) ||
      (mode_reg == `SSP_MODE_SLV7_INT) || (mode_reg == `SSP_MODE_SLV10_INT);
    tenbit = (mode_reg == `SSP_MODE_SLV10) || (mode_reg == `SSP_MODE_SLV10_INT);
    with_int = (mode_reg == `SSP_MODE_SLV7_INT) || (mode_reg == `SSP_MODE_SLV10_INT);
    fwm = (mode_reg == `SSP_MODE_FW_MASTER);
    active = en_reg & (slave | fwm);
    irq_set = 1'b0;
    load_tx = 1'b0;
    push = 1'b0;
    state_next = state_reg;
    base_next = base_reg;
    done_next = done_reg;
    ack_next = ack_reg;
    sda_oe_next = data_pin_oe;
    scl_oe_next = clock_pin_oe;
    en_next = en_reg;
    mode_next = mode_reg;
    ov_next = ov_reg;
    start_next = start_reg;
    stop_next = stop_reg;
    da_next = da_reg;
    rw_next = rw_reg;
    ua_next = ua_reg;
    hi_next = hi_reg;
    addr_next = slave_address_reg;
    tx_next = tx_reg;
    tx_full_next = tx_full;
    // Software side writes; overflow clears only by writing zero
    if (ctrl_write) begin
      en_next = ctrl_wdata[`SSP_CTRL_EN_BIT];
      mode_next = ctrl_wdata[`SSP_CTRL_MODE_HI:`SSP_CTRL_MODE_LO];
      ov_next = ov_reg & ctrl_wdata[`SSP_CTRL_OV_BIT];
    end
    if (addr_write) begin
      addr_next = addr_wdata;
      ua_next = 1'b0;
    end
    // A write while a byte is pending is ignored
    if (tx_write && !tx_full) begin
      tx_next = tx_wdata;
      tx_full_next = 1'b1;
    end
    if (!active) begin
      state_next = SSP_ST_IDLE;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
    end else if (start_det) begin
      start_next = 1'b1;
      stop_next = 1'b0;
      irq_set = with_int | fwm;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
      done_next = 1'b0;
      base_next = edge_bin;
      // Address matching stays idle for firmware master
      state_next = slave ? SSP_ST_ADDR : SSP_ST_IDLE;
    end else if (stop_det) begin
      stop_next = 1'b1;
      start_next = 1'b0;
      irq_set = with_int | fwm;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
      hi_next = 1'b0;
      state_next = SSP_ST_IDLE;
    end else if (state_reg == SSP_ST_ADDR || state_reg == SSP_ST_ADDR_LO || state_reg == SSP_ST_RX) begin
      if (nbits == `SSP_DATA_EDGES && !done_reg) begin
        done_next = 1'b1;
        ack_next = 1'b0;
        if (state_reg == SSP_ST_ADDR) begin
          da_next = 1'b0;
          if (tenbit) begin
            // High byte compare ignores the direction bit
            if (rx_byte[7:3] == `SSP_TEN_BIT_PREFIX && rx_byte[2:1] == slave_address_reg[2:1]) begin
              if (rx_byte[0]) begin
                ack_next = hi_reg;
                rw_next = 1'b1;
                state_next = hi_reg ? SSP_ST_ADDR : SSP_ST_IGNORE;
              end else begin
                ack_next = 1'b1;
                hi_next = 1'b1;
                rw_next = 1'b0;
                state_next = SSP_ST_ADDR_LO;
              end
            end else begin
              state_next = SSP_ST_IGNORE;
            end
          end else if (rx_byte[7:1] == slave_address_reg[7:1] && rx_byte[7:1] != 7'h00) begin
            ack_next = 1'b1;
            rw_next = rx_byte[0];
            state_next = rx_byte[0] ? SSP_ST_ADDR : SSP_ST_RX;
          end else begin
            state_next = SSP_ST_IGNORE;
          end
        end else if (state_reg == SSP_ST_ADDR_LO) begin
          da_next = 1'b0;
          ack_next = (rx_byte == slave_address_reg);
          state_next = (rx_byte == slave_address_reg) ? SSP_ST_RX : SSP_ST_IGNORE;
        end else begin
          da_next = 1'b1;
          ack_next = 1'b1;
        end
        // Matched bytes go to software through the buffer
        if (ack_next) begin
          if (buf_ready) begin
            push = 1'b1;
            irq_set = 1'b1;
            // Software reloads the address register after each part
            if (tenbit && state_reg != SSP_ST_RX) begin
              ua_next = 1'b1;
            end
          end else begin
            ov_next = 1'b1;
            ack_next = 1'b0;
            state_next = SSP_ST_IGNORE;
          end
        end
      end
      if (fall && nbits == `SSP_DATA_EDGES && done_reg && ack_reg) begin
        sda_oe_next = 1'b1;
      end
      if (fall && nbits == `SSP_ACK_EDGE) begin
        sda_oe_next = 1'b0;
        base_next = base_reg + `SSP_ACK_EDGE;
        done_next = 1'b0;
        // A read turns round only after its address acknowledge, else the
        // eighth fall would be taken for the end of a sent byte
        if (state_reg == SSP_ST_ADDR && rw_reg && ack_reg) begin
          state_next = SSP_ST_TX;
        end
      end
    end else if (state_reg == SSP_ST_TX) begin
      if (clock_pin_oe && tx_full) begin
        scl_oe_next = 1'b0;
        load_tx = 1'b1;
      end
      if (fall && nbits != 4'h0 && nbits < `SSP_DATA_EDGES) begin
        sda_oe_next = ~tx_reg[3'h7 - nbits[2:0]];
      end
      if (fall && nbits == `SSP_DATA_EDGES) begin
        sda_oe_next = 1'b0;
        tx_full_next = 1'b0;
        irq_set = 1'b1;
      end
      if (nbits == `SSP_ACK_EDGE && !done_reg) begin
        done_next = 1'b1;
        ack_next = ~bit_shifter[0];
      end
      if (fall && nbits == `SSP_ACK_EDGE) begin
        base_next = base_reg + `SSP_ACK_EDGE;
        done_next = 1'b0;
        if (!ack_reg) begin
          state_next = SSP_ST_IGNORE;
        end
      end
    end
    // First data bit follows the acknowledge of the read address or byte
    if (active && !start_det && !stop_det && fall && nbits == `SSP_ACK_EDGE && ack_reg &&
        state_next == SSP_ST_TX) begin
      if (tx_full) begin
        load_tx = 1'b1;
      end else begin
        sda_oe_next = 1'b0;
        scl_oe_next = 1'b1;
      end
    end
    if (load_tx) begin
      sda_oe_next = ~tx_reg[7];
    end
    // Drive only with both pins set as inputs
    if (!(active && port_c_direction == 2'b11)) begin
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
    end
    // Set wins over a clear in the same cycle
    irqf_next = (port_irq_flag & ~irq_flag_clear) | irq_set;
    irq_next = irqf_next & port_irq_enable;
    // Built from next-state values, BF aside (current rx_valid), so an address write clears UA in the same cycle
    status_next = 8'h00;
    status_next[`SSP_STAT_DA_BIT] = da_next;
    status_next[`SSP_STAT_STOP_BIT] = stop_next;
    status_next[`SSP_STAT_START_BIT] = start_next;
    status_next[`SSP_STAT_RW_BIT] = rw_next;
    status_next[`SSP_STAT_UA_BIT] = ua_next;
    status_next[`SSP_STAT_BF_BIT] = rx_valid;
  end

  // ----------------------------------------------------------------------
  // Core registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= SSP_ST_IDLE;
      base_reg <= 4'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      done_reg <= 1'b0;
      ack_reg <= 1'b0;
      data_pin_oe <= 1'b0;
      clock_pin_oe <= 1'b0;
      data_pin_out <= 1'b0;
      clock_pin_out <= 1'b0;
      en_reg <= 1'b0;
      mode_reg <= 4'h0;
      ov_reg <= 1'b0;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
      da_reg <= 1'b0;
      rw_reg <= 1'b0;
      ua_reg <= 1'b0;
      hi_reg <= 1'b0;
      slave_address_reg <= `SSP_ADDR_RESET;
      tx_reg <= 8'h00;
      tx_full <= 1'b0;
      port_irq_flag <= 1'b0;
      irq <= 1'b0;
      port_status_reg <= 8'h00;
      port_control_reg <= `SSP_CTRL_RESET;
    end else begin
      state_reg <= state_next;
      base_reg <= base_next;
      scl_q <= pins_s[1];
      sda_q <= pins_s[0];
      done_reg <= done_next;
      ack_reg <= ack_next;
      data_pin_oe <= sda_oe_next;
      clock_pin_oe <= scl_oe_next;
      data_pin_out <= 1'b0;
      clock_pin_out <= 1'b0;
      en_reg <= en_next;
      mode_reg <= mode_next;
      ov_reg <= ov_next;
      start_reg <= start_next;
      stop_reg <= stop_next;
      da_reg <= da_next;
      rw_reg <= rw_next;
      ua_reg <= ua_next;
      hi_reg <= hi_next;
      slave_address_reg <= addr_next;
      tx_reg <= tx_next;
      tx_full <= tx_full_next;
      port_irq_flag <= irqf_next;
      irq <= irq_next;
      port_status_reg <= status_next;
      port_control_reg <= {1'b0, ov_next, en_next, 1'b0, mode_next};
    end
  end

endmodule : ssp_port

`default_nettype wire

//--- sps_port_sva.sv
/*
  Checker for the two-wire slave port, bound to every ssp_port.
  Assumes one core clock domain with a synchronous active-high reset.
*/
`include "ssp_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module sps_port_sva (
  // Core clock and reset
  input wire logic clock,
  input wire logic reset,
  // Pins
  input wire logic clock_pin_out,
  input wire logic clock_pin_oe,
  input wire logic data_pin_out,
  input wire logic data_pin_oe,
  input wire logic [1:0] port_c_direction,
  // Registers
  input wire logic ctrl_write,
  input wire logic [7:0] ctrl_wdata,
  input wire logic [7:0] port_control_reg,
  input wire logic [7:0] port_status_reg,
  input wire logic addr_write,
  input wire logic [7:0] addr_wdata,
  input wire logic [7:0] slave_address_reg,
  // Buffer and interrupt
  input wire logic rx_valid,
  input wire logic irq_flag_clear,
  input wire logic port_irq_enable,
  input wire logic port_irq_flag,
  input wire logic irq
);
  import ssp_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // Three cycles cover the registered lag from enable to pin drive
  sequence s_quiet;
    (!port_control_reg[`SSP_CTRL_EN_BIT] || port_c_direction != 2'b11) [*3];
  endsequence
  property p_quiet;
    s_quiet |-> !clock_pin_oe && !data_pin_oe;
  endproperty
  property p_open_drain;
    clock_pin_out == 1'b0 && data_pin_out == 1'b0;
  endproperty
  property p_ctrl;
    ctrl_write |=> port_control_reg[5] == $past(ctrl_wdata[5]) && port_control_reg[3:0] == $past(ctrl_wdata[3:0]);
  endproperty
  property p_addr;
    addr_write |=> slave_address_reg == $past(addr_wdata);
  endproperty
  property p_ov_cause;
    $rose(port_control_reg[`SSP_CTRL_OV_BIT]) |-> $past(rx_valid);
  endproperty
  property p_ov_hold;
    port_control_reg[`SSP_CTRL_OV_BIT] && !ctrl_write |=> port_control_reg[`SSP_CTRL_OV_BIT];
  endproperty
  property p_flag_hold;
    port_irq_flag && !irq_flag_clear |=> port_irq_flag;
  endproperty
  property p_irq;
    irq == (port_irq_flag && $past(port_irq_enable));
  endproperty
  property p_full;
    port_status_reg[`SSP_STAT_BF_BIT] == $past(rx_valid);
  endproperty
  property p_fw_idle;
    $rose(rx_valid) |-> port_control_reg[3:0] != `SSP_MODE_FW_MASTER;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pin driven while port off");
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  a_ctrl: assert property (p_ctrl) else $error("control fields not loaded");
  a_addr: assert property (p_addr) else $error("address not loaded");
  a_ov_cause: assert property (p_ov_cause) else $error("overflow without full buffer");
  a_ov_hold: assert property (p_ov_hold) else $error("overflow cleared by itself");
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by itself");
  a_irq: assert property (p_irq) else $error("request not flag and enable");
  a_full: assert property (p_full) else $error("buffer full bit wrong");
  a_fw_idle: assert property (p_fw_idle) else $error("byte taken in master mode");
endmodule : sps_port_sva

bind ssp_port sps_port_sva sps_port_sva_inst (.clock, .reset, .clock_pin_out, .clock_pin_oe, .data_pin_out,
  .data_pin_oe, .port_c_direction, .ctrl_write, .ctrl_wdata, .port_control_reg, .port_status_reg, .addr_write,
  .addr_wdata, .slave_address_reg, .rx_valid, .irq_flag_clear, .port_irq_enable, .port_irq_flag, .irq);
`default_nettype wire

//--- sps_bus_master.sv
/*
  Behavioural two-wire bus master, 32 ns bit period.
  Assumes pull-ups: the bench ands each drive with the port's pull-down.
*/
`timescale 1ns/1ns
`default_nettype none

module sps_bus_master (
  // Drive, 1 releases the line
  output logic m_scl,
  output logic m_sda,
  // Resolved lines
  input wire logic scl_w,
  input wire logic sda_w
);
  // One clock rise while the port is in reset lets its link side see it
  initial begin
    m_scl = 1'b0;
    m_sda = 1'b1;
    #3 m_scl = 1'b1;
  end
  // Clock pulses with data high, outside any frame, finish the link reset
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      #16 m_scl = 1'b0;
      #16 m_scl = 1'b1;
    end
  endtask : idle_clocks
  // Clock stands high between frames; waits honour stretching
  task automatic start_cond;
    m_sda = 1'b1;
    #8 m_scl = 1'b1;
    wait (scl_w === 1'b1);
    #16 m_sda = 1'b0;
    #16 m_scl = 1'b0;
  endtask : start_cond
  task automatic stop_cond;
    #8 m_sda = 1'b0;
    #8 m_scl = 1'b1;
    wait (scl_w === 1'b1);
    #16 m_sda = 1'b1;
    #16;
  endtask : stop_cond
  task automatic xfer(input logic [7:0] b, output logic ack, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      #8 m_sda = b[i];
      #8 m_scl = 1'b1;
      wait (scl_w === 1'b1);
      #15 r[i] = (sda_w === 1'b1);
      #1 m_scl = 1'b0;
    end
    #8 m_sda = 1'b1;
    #8 m_scl = 1'b1;
    wait (scl_w === 1'b1);
    #15 ack = (sda_w === 1'b0);
    #1 m_scl = 1'b0;
  endtask : xfer
endmodule : sps_bus_master
`default_nettype wire

//--- test_sync_serial_port_two_wire_slave.sv
/*
  Self-checking bench for the two-wire slave port.
  Assumes the design, the checker and the bus master model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module test_sync_serial_port_two_wire_slave;
  import ssp_pkg::*;
  logic clock, reset, ctrl_write, addr_write, irq_flag_clear, port_irq_enable, hold, tx_write, rd_ack;
  logic rx_ready = 1'b0;
  logic [1:0] port_c_direction;
  logic [7:0] ctrl_wdata, addr_wdata, d1, tx_wdata, tx_b, rd;
  wire logic clock_pin_out, clock_pin_oe, data_pin_out, data_pin_oe, rx_valid, tx_full, port_irq_flag, irq;
  wire logic m_scl, m_sda;
  wire logic [7:0] port_control_reg, port_status_reg, slave_address_reg, rx_data;
  wire logic scl_w = m_scl & ~clock_pin_oe;
  wire logic sda_w = m_sda & ~data_pin_oe;
  int n_errors = 0;
  int n_compared = 0;
  logic [7:0] exp_q[$];

  ssp_port ssp_port_inst (.clock, .reset, .link_clock(scl_w), .clock_pin_in(scl_w), .clock_pin_out, .clock_pin_oe,
    .data_pin_in(sda_w), .data_pin_out, .data_pin_oe, .port_c_direction, .ctrl_write, .ctrl_wdata, .port_control_reg,
    .port_status_reg, .addr_write, .addr_wdata, .slave_address_reg, .rx_valid, .rx_data, .rx_ready,
    .tx_write, .tx_wdata, .tx_full, .irq_flag_clear, .port_irq_enable, .port_irq_flag, .irq);
  sps_bus_master sps_bus_master_inst (.m_scl, .m_sda, .scl_w, .sda_w);

  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    n_compared++;
    if (seen !== expected) begin
      n_errors++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, expected);
    end
  endtask : check
  task automatic finish_test;
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic ctrl(input logic [7:0] v);
    @(negedge clock) ctrl_write = 1'b1;
    ctrl_wdata = v;
    @(negedge clock) ctrl_write = 1'b0;
  endtask : ctrl
  task automatic addr(input logic [7:0] v);
    @(negedge clock) addr_write = 1'b1;
    addr_wdata = v;
    @(negedge clock) addr_write = 1'b0;
  endtask : addr
  task automatic send(input logic [7:0] b, input logic e);
    logic a;
    logic [7:0] r;
    sps_bus_master_inst.xfer(b, a, r);
    check({7'h00, a}, {7'h00, e});
  endtask : send

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Receiver side stalls at random unless held
  always @(negedge clock) rx_ready <= hold ? 1'b0 : 1'($urandom_range(1));
  always @(posedge clock) begin
    if (reset === 1'b0 && rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_q.size() == 0) check(8'h00, 8'h01);
      else check(rx_data, exp_q.pop_front());
    end
  end
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end

  initial begin
    reset = 1'b1;
    ctrl_write = 1'b0;
    ctrl_wdata = 8'h00;
    addr_write = 1'b0;
    addr_wdata = 8'h00;
    tx_write = 1'b0;
    tx_wdata = 8'h00;
    irq_flag_clear = 1'b0;
    port_irq_enable = 1'b0;
    port_c_direction = 2'b00;
    hold = 1'b1;
    void'($urandom(2267));
    repeat (5) @(negedge clock);
    reset = 1'b0;
    sps_bus_master_inst.idle_clocks(3);
    @(negedge clock);
    check(port_control_reg, 8'h00);
    check(port_status_reg, 8'h00);
    check({5'h00, irq, data_pin_oe, clock_pin_oe}, 8'h00);
    for (int m = 1; m <= 5; m++) begin
      ctrl(8'h20 | 8'(m));
      check(port_control_reg, 8'h20 | 8'(m));
    end
    port_c_direction = 2'b11;
    port_irq_enable = 1'b1;
    addr(8'h54);
    check(slave_address_reg, 8'h54);
    ctrl(8'h23);
    d1 = 8'($urandom);
    exp_q.push_back(8'h54);
    exp_q.push_back(d1);
    sps_bus_master_inst.start_cond();
    send(8'h54, 1'b1);
    send(d1, 1'b1);
    send(8'($urandom), 1'b0);
    sps_bus_master_inst.stop_cond();
    repeat (8) @(negedge clock);
    check({5'h00, port_control_reg[6], port_irq_flag, irq}, 8'h07);
    check(port_status_reg & 8'h30, 8'h30);
    hold = 1'b0;
    repeat (40) @(negedge clock);
    check(8'(exp_q.size()), 8'h00);
    ctrl(8'h23);
    check(port_control_reg, 8'h23);
    @(negedge clock) irq_flag_clear = 1'b1;
    @(negedge clock) irq_flag_clear = 1'b0;
    check({7'h00, port_irq_flag}, 8'h00);
    // Foreign address, then general call: neither is acknowledged
    for (int i = 0; i < 2; i++) begin
      if (i) addr(8'h00);
      sps_bus_master_inst.start_cond();
      send(i ? 8'h00 : 8'h56, 1'b0);
      sps_bus_master_inst.stop_cond();
    end
    addr(8'h54);
    ctrl(8'h25);
    sps_bus_master_inst.start_cond();
    send(8'h54, 1'b0);
    sps_bus_master_inst.stop_cond();
    repeat (8) @(negedge clock);
    check(port_status_reg & 8'h10, 8'h10);
    ctrl(8'h22);
    addr(8'hF2);
    exp_q.push_back(8'hF2);
    exp_q.push_back(8'h5A);
    sps_bus_master_inst.start_cond();
    send(8'hF2, 1'b1);
    check(port_status_reg & 8'h02, 8'h02);
    addr(8'h5A);
    send(8'h5A, 1'b1);
    sps_bus_master_inst.stop_cond();
    // Read of one byte, ended by the master's not-acknowledge
    ctrl(8'h23);
    addr(8'h54);
    tx_b = 8'($urandom);
    @(negedge clock) tx_write = 1'b1;
    tx_wdata = tx_b;
    @(negedge clock) tx_write = 1'b0;
    check({7'h00, tx_full}, 8'h01);
    exp_q.push_back(8'h55);
    sps_bus_master_inst.start_cond();
    send(8'h55, 1'b1);
    check(port_status_reg & 8'h04, 8'h04);
    sps_bus_master_inst.xfer(8'hFF, rd_ack, rd);
    check(rd, tx_b);
    check({6'h00, rd_ack, tx_full}, 8'h00);
    sps_bus_master_inst.stop_cond();
    repeat (40) @(negedge clock);
    check(8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule : test_sync_serial_port_two_wire_slave
`default_nettype wire
